// ### shared/atc_defs.svh
// Purpose: constants for the acquisition trigger control block
// Assumes: 32-bit avalon-mm register words, word addresses
// Notes:   included by bare name
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH

`define ATC_REG_CTRL      4'h0
`define ATC_REG_LEVEL     4'h1
`define ATC_REG_TIMEBASE  4'h2
`define ATC_REG_HOLDOFF   4'h3
`define ATC_REG_RECORD    4'h4
`define ATC_REG_STATUS    4'h5
`define ATC_REG_TRIGPOS   4'h6
`define ATC_REG_FORCE     4'h7

`define ATC_CTRL_RUN      0
`define ATC_CTRL_AUTO     1
`define ATC_CTRL_SLOPE    2
`define ATC_CTRL_SRC_LO   4
`define ATC_CTRL_SRC_HI   6
`define ATC_CTRL_TYPE_LO  8
`define ATC_CTRL_TYPE_HI  9
`define ATC_CTRL_PULSE_LO 12
`define ATC_CTRL_PULSE_HI 13
`define ATC_CTRL_LOGIC_LO 16
`define ATC_CTRL_LOGIC_HI 19
`define ATC_CTRL_LMODE    20
`define ATC_CTRL_LFUNC    21

`define ATC_ST_DONE       0
`define ATC_ST_REAL       1
`define ATC_ST_ARMED      2
`define ATC_ST_BUSY       3

`define ATC_AUTO_SHIFT    5'd8
`define ATC_HOLD_MIN      16'h0010
`define ATC_TRIG_FORCE    2'd0
`define ATC_TRIG_REAL     2'd1

`endif

// ### shared/atc_pkg.sv
// Purpose: types for the acquisition trigger control block
// Assumes: nothing
// Notes:   constants live in atc_defs.svh
package atc_pkg;
    typedef enum logic [2:0] {
        ATC_IDLE    = 3'b000,
        ATC_FILL    = 3'b001,
        ATC_ARMED   = 3'b010,
        ATC_POST    = 3'b011,
        ATC_HOLDOFF = 3'b100
    } atc_state_t;

    typedef enum logic [2:0] {
        ATC_SRC_CH1  = 3'b000,
        ATC_SRC_CH2  = 3'b001,
        ATC_SRC_CH3  = 3'b010,
        ATC_SRC_CH4  = 3'b011,
        ATC_SRC_LINE = 3'b100,
        ATC_SRC_AUX  = 3'b101
    } atc_src_t;

    typedef enum logic [1:0] {
        ATC_TYPE_EDGE  = 2'b00,
        ATC_TYPE_PULSE = 2'b01,
        ATC_TYPE_LOGIC = 2'b10
    } atc_type_t;

    typedef enum logic [1:0] {
        ATC_PULSE_WIDTH = 2'b00,
        ATC_PULSE_RUNT  = 2'b01,
        ATC_PULSE_GLTCH = 2'b10
    } atc_pulse_t;
endpackage

// ### core/atc_trigger_ctrl.sv
// Purpose: trigger control for a sampling acquisition system
// Assumes: comparator outputs and pins are asynchronous, two-flop synced here
// Notes:   registers over avalon-mm; one sample per clock written to memory
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`include "atc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module atc_trigger_ctrl
    import atc_pkg::*;
#(
    parameter int DEPTH_W = 10,
    parameter int LINE_DIV = 416667  // 25 MHz / 60 Hz
) (
    input  wire logic                clk,              // sample clock, 25 MHz
    input  wire logic                reset,            // async, active high
    input  wire logic [3:0]          ch_above,         // comparator: channel above level
    input  wire logic                aux_trig,         // auxiliary trigger pin
    input  wire logic                line_ref,         // mains reference pin
    input  wire logic [3:0]          ch_display_en,    // display enables, not used for trigger
    input  wire logic [3:0]          avs_address,      // word address
    input  wire logic                avs_read,         // read strobe
    input  wire logic                avs_write,        // write strobe
    input  wire logic [31:0]         avs_writedata,    // write data
    input  wire logic [3:0]          avs_byteenable,   // byte enables
    output logic      [31:0]         avs_readdata,     // read data
    output logic                     avs_waitrequest,  // stall
    output logic      [11:0]         level_dac,        // threshold to comparators
    output logic                     mem_we,           // sample write strobe
    output logic      [DEPTH_W-1:0]  mem_addr,         // sample write address
    output logic                     trig_pulse,       // accepted trigger, one cycle
    output logic                     acq_done          // acquisition complete flag
);
    localparam logic [DEPTH_W-1:0] ONE = DEPTH_W'(1);

    logic [3:0]  ch_s1_q, ch_s2_q, ch_prev_q;
    logic [1:0]  aux_s_q;
    logic [1:0]  line_s_q;
    logic        aux_prev_q, line_prev_q;
    logic [31:0] ctrl_q, timebase_q, record_q;
    logic [11:0] level_q;
    logic [7:0]  holdoff_q;
    logic        force_req_q, done_q, real_q, rd_ack_q;
    logic [DEPTH_W-1:0] trig_pos_q, wr_ptr_q, cnt_q;
    logic [31:0] timer_q, hold_cnt_q;
    atc_state_t  state_q;

    // register bus: one wait cycle on reads, writes accepted at once
    wire bus_wr = avs_write;
    assign avs_waitrequest = avs_read & ~rd_ack_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= avs_read & ~rd_ack_q;
        end
    end

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                old[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return old;
    endfunction

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q     <= 32'h0000_0000;
            level_q    <= 12'h800;
            timebase_q <= 32'h0000_0100;
            holdoff_q  <= 8'h00;
            record_q   <= 32'h0000_0200;
        end else if (bus_wr) begin
            if (avs_address == `ATC_REG_CTRL) begin
                ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
            end else if (avs_address == `ATC_REG_LEVEL) begin
                level_q <= 12'(be_merge({20'h0, level_q}, avs_writedata, avs_byteenable));
            end else if (avs_address == `ATC_REG_TIMEBASE) begin
                timebase_q <= be_merge(timebase_q, avs_writedata, avs_byteenable);
            end else if (avs_address == `ATC_REG_HOLDOFF) begin
                holdoff_q <= avs_byteenable[0] ? avs_writedata[7:0] : holdoff_q;
            end else if (avs_address == `ATC_REG_RECORD) begin
                record_q <= be_merge(record_q, avs_writedata, avs_byteenable);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~rd_ack_q) begin
            if (avs_address == `ATC_REG_CTRL) begin
                avs_readdata <= ctrl_q;
            end else if (avs_address == `ATC_REG_LEVEL) begin
                avs_readdata <= {20'h0, level_q};
            end else if (avs_address == `ATC_REG_TIMEBASE) begin
                avs_readdata <= timebase_q;
            end else if (avs_address == `ATC_REG_HOLDOFF) begin
                avs_readdata <= {24'h0, holdoff_q};
            end else if (avs_address == `ATC_REG_RECORD) begin
                avs_readdata <= record_q;
            end else if (avs_address == `ATC_REG_STATUS) begin
                avs_readdata <= {28'h0, state_q == ATC_POST, state_q == ATC_ARMED,
                                 real_q, done_q};
            end else if (avs_address == `ATC_REG_TRIGPOS) begin
                avs_readdata <= 32'(trig_pos_q);
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end
    assign level_dac = level_q;
    // input synchronisers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ch_s1_q     <= 4'h0;
            ch_s2_q     <= 4'h0;
            ch_prev_q   <= 4'h0;
            aux_s_q     <= 2'h0;
            line_s_q    <= 2'h0;
            aux_prev_q  <= 1'b0;
            line_prev_q <= 1'b0;
        end else begin
            ch_s1_q     <= ch_above;
            ch_s2_q     <= ch_s1_q;
            ch_prev_q   <= ch_s2_q;
            aux_s_q     <= {aux_s_q[0], aux_trig};
            line_s_q    <= {line_s_q[0], line_ref};
            aux_prev_q  <= aux_s_q[1];
            line_prev_q <= line_s_q[1];
        end
    end
    // source select; display enables deliberately ignored
    atc_src_t src;
    logic     cur, prev;
    assign src = atc_src_t'(ctrl_q[`ATC_CTRL_SRC_HI:`ATC_CTRL_SRC_LO]);
    always_comb begin
        cur  = 1'b0;
        prev = 1'b0;
        case (src)
            ATC_SRC_CH1, ATC_SRC_CH2, ATC_SRC_CH3, ATC_SRC_CH4: begin
                cur  = ch_s2_q[src[1:0]];
                prev = ch_prev_q[src[1:0]];
            end
            ATC_SRC_LINE: begin
                cur  = line_s_q[1];
                prev = line_prev_q;
            end
            ATC_SRC_AUX: begin
                cur  = aux_s_q[1];
                prev = aux_prev_q;
            end
            default: ;
        endcase
    end
    // edge, pulse and logic event detection
    wire slope_fall = ctrl_q[`ATC_CTRL_SLOPE];
    wire edge_ev = slope_fall ? (prev & ~cur) : (~prev & cur);
    atc_type_t  ttype;
    atc_pulse_t pclass;
    assign ttype  = atc_type_t'(ctrl_q[`ATC_CTRL_TYPE_HI:`ATC_CTRL_TYPE_LO]);
    assign pclass = atc_pulse_t'(ctrl_q[`ATC_CTRL_PULSE_HI:`ATC_CTRL_PULSE_LO]);
    logic [15:0] pw_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pw_q <= 16'h0000;
        end else if (cur != prev) begin
            pw_q <= 16'h0001;
        end else if (pw_q != 16'hffff) begin
            pw_q <= pw_q + 16'h0001;
        end
    end
    // pulse end: width compares against level bits as qualifier limit
    wire pulse_end = slope_fall ? (~prev & cur) : (prev & ~cur);
    logic pulse_ev;
    always_comb begin
        case (pclass)
            ATC_PULSE_WIDTH: pulse_ev = pulse_end & (pw_q >= {8'h0, level_q[11:4]});
            ATC_PULSE_GLTCH: pulse_ev = pulse_end & (pw_q < {8'h0, level_q[11:4]});
            ATC_PULSE_RUNT:  pulse_ev = edge_ev & (ch_s2_q == 4'h0);
            default:         pulse_ev = 1'b0;
        endcase
    end
    wire [3:0] lmask = ctrl_q[`ATC_CTRL_LOGIC_HI:`ATC_CTRL_LOGIC_LO];
    wire lterm = ctrl_q[`ATC_CTRL_LFUNC] ? |(ch_s2_q & lmask)
                                         : ((ch_s2_q & lmask) == lmask);
    logic lterm_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lterm_q <= 1'b0;
        end else begin
            lterm_q <= lterm;
        end
    end
    // state variant gated by source edge, pattern on becoming true
    wire logic_ev = ctrl_q[`ATC_CTRL_LMODE] ? (edge_ev & lterm)
                                            : (lterm & ~lterm_q);
    logic real_ev;
    always_comb begin
        case (ttype)
            ATC_TYPE_PULSE: real_ev = pulse_ev;
            ATC_TYPE_LOGIC: real_ev = logic_ev;
            default:        real_ev = edge_ev;
        endcase
    end
    // force request: set wins over consumption
    wire force_wr = bus_wr && avs_address == `ATC_REG_FORCE && avs_writedata[0];
    wire run = ctrl_q[`ATC_CTRL_RUN];
    wire auto_mode = ctrl_q[`ATC_CTRL_AUTO];
    wire [31:0] auto_limit = timebase_q << `ATC_AUTO_SHIFT;
    wire timeout = auto_mode && timer_q >= auto_limit;
    wire armed = state_q == ATC_ARMED;
    wire take_real  = armed & real_ev;
    wire take_force = armed & ~real_ev & (force_req_q | timeout);
    wire accept = take_real | take_force;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            force_req_q <= 1'b0;
        end else if (force_wr) begin
            force_req_q <= 1'b1;
        end else if (accept) begin
            force_req_q <= 1'b0;
        end
    end
    // auto timer restarts on every real event
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_q <= 32'h0;
        end else if (real_ev | accept | ~armed) begin
            timer_q <= 32'h0;
        end else if (!timeout) begin
            timer_q <= timer_q + 32'h1;
        end
    end
    wire [DEPTH_W-1:0] pre_len  = record_q[DEPTH_W-1:0];
    wire [DEPTH_W-1:0] post_len = record_q[16 +: DEPTH_W];
    // holdoff scales min..max with time base
    wire [31:0] hold_len = 32'(`ATC_HOLD_MIN) + timebase_q * {24'h0, holdoff_q};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q    <= ATC_IDLE;
            cnt_q      <= '0;
            hold_cnt_q <= 32'h0;
        end else begin
            case (state_q)
                ATC_IDLE: begin
                    cnt_q <= '0;
                    if (run) begin
                        state_q <= ATC_FILL;
                    end
                end
                ATC_FILL: begin
                    cnt_q <= cnt_q + ONE;
                    if (cnt_q + ONE >= pre_len) begin
                        state_q <= ATC_ARMED;
                    end
                end
                ATC_ARMED: begin
                    cnt_q <= '0;
                    if (accept) begin
                        state_q <= ATC_POST;
                    end else if (!run) begin
                        state_q <= ATC_IDLE;
                    end
                end
                ATC_POST: begin
                    cnt_q <= cnt_q + ONE;
                    if (cnt_q + ONE >= post_len) begin
                        state_q    <= ATC_HOLDOFF;
                        hold_cnt_q <= 32'h0;
                    end
                end
                ATC_HOLDOFF: begin
                    hold_cnt_q <= hold_cnt_q + 32'h1;
                    if (hold_cnt_q + 32'h1 >= hold_len) begin
                        state_q <= ATC_IDLE;
                    end
                end
                default: state_q <= ATC_IDLE;
            endcase
        end
    end
    // circular sample memory write pointer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
        end else if (mem_we) begin
            wr_ptr_q <= wr_ptr_q + ONE;
        end
    end
    assign mem_we   = state_q == ATC_FILL || armed || state_q == ATC_POST;
    assign mem_addr = wr_ptr_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trig_pos_q <= '0;
            real_q     <= 1'b0;
            done_q     <= 1'b0;
            trig_pulse <= 1'b0;
        end else begin
            trig_pulse <= accept;
            if (accept) begin
                trig_pos_q <= wr_ptr_q;
                real_q     <= take_real;
            end
            if (state_q == ATC_POST && cnt_q + ONE >= post_len) begin
                done_q <= 1'b1;
            end else if (bus_wr && avs_address == `ATC_REG_STATUS
                         && avs_writedata[`ATC_ST_DONE]) begin
                done_q <= 1'b0;
            end
        end
    end
    assign acq_done = done_q;
endmodule // atc_trigger_ctrl
`default_nettype wire

// ### test/atc_props.sv
// Purpose: port assertions for the trigger control block
// Assumes: one clock, async active-high reset
// Notes:   bound to atc_trigger_ctrl below
`timescale 1ns/10ps
`default_nettype none
module atc_props #(
    parameter int DEPTH_W  = 10,
    parameter int LINE_DIV = 416667
) (
    input wire logic               clk,             // sample clock
    input wire logic               reset,           // async reset
    input wire logic               avs_read,        // read strobe
    input wire logic               avs_write,       // write strobe
    input wire logic               avs_waitrequest, // stall
    input wire logic [11:0]        level_dac,       // threshold
    input wire logic               mem_we,          // sample strobe
    input wire logic [DEPTH_W-1:0] mem_addr,        // sample address
    input wire logic               trig_pulse,      // accepted trigger
    input wire logic               acq_done         // done flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_trig_single;
        trig_pulse |=> !trig_pulse;
    endproperty
    a_trig_single: assert property (p_trig_single)
        else $error("trigger pulse longer than one cycle");
    property p_no_retrig;
        trig_pulse |=> !trig_pulse [*8];
    endproperty
    a_no_retrig: assert property (p_no_retrig)
        else $error("second trigger during acquisition");
    property p_armed_only;
        trig_pulse |-> mem_we;
    endproperty
    a_armed_only: assert property (p_armed_only)
        else $error("trigger while not sampling");
    property p_post_collect;
        trig_pulse |=> mem_we [*2];
    endproperty
    a_post_collect: assert property (p_post_collect)
        else $error("no post-trigger samples");
    property p_addr_step;
        mem_we |=> mem_addr == DEPTH_W'($past(mem_addr) + 1'b1);
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("sample pointer did not advance");
    property p_addr_hold;
        !mem_we |=> $stable(mem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("sample pointer moved without a write");
    property p_done_bound;
        trig_pulse |-> ##[1:300] acq_done;
    endproperty
    a_done_bound: assert property (p_done_bound)
        else $error("acquisition never completed");
    property p_level_hold;
        !avs_write |=> $stable(level_dac);
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("threshold changed without a write");
    property p_read_wait;
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read stall not one cycle");

    c_trig: cover property (trig_pulse);
    c_done: cover property ($rose(acq_done));
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule // atc_props

bind atc_trigger_ctrl atc_props #(.DEPTH_W(DEPTH_W), .LINE_DIV(LINE_DIV)) u_props (
    .clk(clk), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .level_dac(level_dac), .mem_we(mem_we),
    .mem_addr(mem_addr), .trig_pulse(trig_pulse), .acq_done(acq_done));
`default_nettype wire

// ### test/atc_front_end.sv
// Purpose: comparators and sample memory at the far side
// Assumes: input levels given as 12-bit codes
// Notes:   counts sample writes for the bench
`timescale 1ns/10ps
`default_nettype none
module atc_front_end #(
    parameter int DEPTH_W = 10
) (
    input  wire logic               clk,      // sample clock
    input  wire logic [11:0]        level_dac,// threshold
    input  wire logic [47:0]        ch_lvl,   // four input levels
    input  wire logic               mem_we,   // sample strobe
    input  wire logic [DEPTH_W-1:0] mem_addr, // sample address
    output logic      [3:0]         ch_above, // comparator outputs
    output logic      [31:0]        n_writes  // samples stored
);
    logic [11:0] mem_q [2**DEPTH_W];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ch_above[i] = ch_lvl[i*12 +: 12] > level_dac;
        end
    end

    initial n_writes = '0;
    always @(posedge clk) begin
        if (mem_we) begin
            mem_q[mem_addr] <= ch_lvl[11:0];
            n_writes <= n_writes + 1;
        end
    end
endmodule // atc_front_end
`default_nettype wire

// ### test/acquisition_trigger_control_bench.sv
// Purpose: self-checking bench for the trigger control block
// Assumes: timebase 1 (1 and 2 in the auto test), pre 4, post 4, holdoff code 0
// Notes:   reads are checked against a queue of expectations
`include "atc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module acquisition_trigger_control_bench;
    import atc_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [47:0] ch_lvl = '0;
    logic        aux_trig = 1'b0;
    logic        line_ref = 1'b0;
    logic [3:0]  ch_en = '0;
    logic [3:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, n_writes, w0, tpos;
    logic        avs_waitrequest, mem_we, trig_pulse, acq_done;
    logic [11:0] level_dac, lvl;
    logic [9:0]  mem_addr;
    logic [3:0]  ch_above;
    logic [2:0]  src;
    logic [31:0] rng = 32'hcbc5f6a6;
    logic [31:0] exp_q[$], msk_q[$];
    int          n_errors = 0, cmp_count = 0, n_trig = 0, n0, c, fall;
    int          cyc = 0, last_t = 0, min_gap = 100000;

    always #20 clk = ~clk;

    atc_trigger_ctrl #(.DEPTH_W(10), .LINE_DIV(100)) dut_u (
        .clk(clk), .reset(reset), .ch_above(ch_above), .aux_trig(aux_trig),
        .line_ref(line_ref), .ch_display_en(ch_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .level_dac(level_dac),
        .mem_we(mem_we), .mem_addr(mem_addr), .trig_pulse(trig_pulse),
        .acq_done(acq_done));
    atc_front_end #(.DEPTH_W(10)) fe_u (
        .clk(clk), .level_dac(level_dac), .ch_lvl(ch_lvl), .mem_we(mem_we),
        .mem_addr(mem_addr), .ch_above(ch_above), .n_writes(n_writes));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    // sets the selected source above or below the threshold
    task automatic drive(input logic [2:0] s, input int v);
        if (s < 3'd4) ch_lvl[s*12 +: 12] <= v ? lvl + 12'h100 : lvl - 12'h100;
        else if (s == 3'd4) line_ref <= v[0];
        else aux_trig <= v[0];
    endtask

    task automatic wait_trig(output int n);
        n = 0;
        while (trig_pulse !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            chk(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
        end
        if (trig_pulse === 1'b1) begin
            if (n_trig > 0 && cyc - last_t < min_gap) min_gap = cyc - last_t;
            last_t = cyc;
            tpos = n_writes - 32'h1;
            n_trig++;
        end
    end

    initial begin
        #2_000_000;
        n_errors++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk({20'h0, level_dac}, 32'h800);
        bus_rd(4'hf, 32'h0, 32'hffffffff);
        rng = xs(rng);
        lvl = 12'h200 + {1'b0, rng[10:0]};
        bus_wr(`ATC_REG_LEVEL, {20'h0, lvl});
        chk({20'h0, level_dac}, {20'h0, lvl});
        bus_rd(`ATC_REG_LEVEL, {20'h0, lvl}, 32'hfff);
        bus_wr(`ATC_REG_TIMEBASE, 32'h1);
        bus_wr(`ATC_REG_RECORD, 32'h0004_0004);
        bus_wr(`ATC_REG_HOLDOFF, 32'h0);
        $display("test registers done");
        for (int s = 0; s < 12; s++) begin
            src = 3'(s % 6);
            fall = s / 6;
            rng = xs(rng);
            ch_en <= rng[3:0];
            drive(src, !fall);
            repeat (4) @(posedge clk);
            bus_wr(`ATC_REG_CTRL, {25'h0, src, 1'b0, fall[0], 2'b01});
            repeat (12) @(posedge clk);
            n0 = n_trig;
            w0 = n_writes;
            drive(src, fall);
            repeat (20) @(posedge clk);
            chk(n_trig - n0, 0);
            chk(n_writes - w0, 20);
            drive(src, !fall);
            wait_trig(c);
            chk(c < 40, 1);
            @(posedge clk);
            drive(src, fall);
            repeat (3) @(posedge clk);
            drive(src, !fall);
            repeat (40) @(posedge clk);
            chk(n_trig - n0, 1);
            chk({31'h0, acq_done}, 1);
            bus_rd(`ATC_REG_STATUS, 32'h3, 32'h3);
            bus_rd(`ATC_REG_TRIGPOS, tpos, 32'h3ff);
            bus_wr(`ATC_REG_STATUS, 32'h1);
            chk({31'h0, acq_done}, 0);
            bus_wr(`ATC_REG_CTRL, 32'h0);
        end
        $display("test edge sources done");
        bus_wr(`ATC_REG_CTRL, 32'h1);
        n0 = n_trig;
        repeat (100) @(posedge clk);
        chk(n_trig - n0, 0);
        bus_wr(`ATC_REG_FORCE, 32'h1);
        repeat (100) @(posedge clk);
        chk(n_trig - n0, 1);
        bus_rd(`ATC_REG_STATUS, 32'h1, 32'h3);
        bus_wr(`ATC_REG_STATUS, 32'h1);
        bus_wr(`ATC_REG_CTRL, 32'h0);
        $display("test force done");
        // runt class on aux while every channel is low
        bus_wr(`ATC_REG_CTRL, 32'h0000_1151);
        repeat (12) @(posedge clk);
        aux_trig <= 1'b1;
        wait_trig(c);
        chk(c < 40, 1);
        // pattern form, and of the two lowest channels
        bus_wr(`ATC_REG_CTRL, 32'h0003_0201);
        repeat (40) @(posedge clk);
        n0 = n_trig;
        drive(3'd0, 1);
        repeat (10) @(posedge clk);
        chk(n_trig - n0, 0);
        drive(3'd1, 1);
        wait_trig(c);
        chk(c < 40, 1);
        bus_wr(`ATC_REG_CTRL, 32'h0);
        aux_trig <= 1'b0;
        repeat (40) @(posedge clk);
        $display("test pulse and logic done");
        for (int tb = 1; tb < 3; tb++) begin
            bus_wr(`ATC_REG_TIMEBASE, tb);
            aux_trig <= 1'b0;
            bus_wr(`ATC_REG_CTRL, 32'h0000_0053);
            for (int k = 0; k < 16; k++) begin
                repeat (8) @(posedge clk);
                aux_trig <= !aux_trig;
            end
            c = 0;
            do begin
                @(posedge clk);
                c++;
            end while (!(trig_pulse === 1'b1 && c > 20) && c < 2000);
            chk(c >= 256 * tb - 40 && c <= 256 * tb + 40, 1);
            repeat (8) @(posedge clk);
            bus_rd(`ATC_REG_STATUS, 32'h1, 32'h3);
            bus_wr(`ATC_REG_CTRL, 32'h0);
            bus_wr(`ATC_REG_STATUS, 32'h1);
        end
        chk(min_gap >= 20, 1);
        chk(exp_q.size(), 0);
        $display("test auto mode and holdoff done");
        test_done();
    end
endmodule // acquisition_trigger_control_bench
`default_nettype wire
